// ===== hw/tw_host_ctrl.sv
// host end: AHB-Lite programmable driver of the three-wire link
// assumes a single AHB-Lite master and the device on the link modport
`timescale 1ns/10ps
`include "tw_regs.svh"
module tw_host_ctrl
  import tw_pkg::*;
#(
  parameter int HALF_CYC = `TW_HALF_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  tw_link_if.host          link
);

  if (HALF_CYC < 4 || HALF_CYC > 255) begin : g_chk
    $error("HALF_CYC must lie between 4 and 255");
  end

  localparam logic [7:0] HALF_LOAD = 8'(HALF_CYC - 1);

  logic        apValid_r, apValid_nxt, apWrite_r, apWrite_nxt;
  logic [7:0]  apAddr_r, apAddr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [15:0] txWord_r, txWord_nxt;
  logic        readMode_r, readMode_nxt, done_r, done_nxt;
  logic        devRst_r, devRst_nxt;
  logic        startPulse, finishPulse, busy, wrPhase;
  tw_hst_e     st_r, st_nxt;
  logic [7:0]  half_r, half_nxt;
  logic [3:0]  bitIdx_r, bitIdx_nxt;
  logic [15:0] txSh_r, txSh_nxt, rxSh_r, rxSh_nxt;
  logic [10:0] rxCode_r, rxCode_nxt;
  logic        sclk_r, sclk_nxt, selN_r, selN_nxt, txBit_r, txBit_nxt;
  logic        rw_r, rw_nxt, rxLvl_r, rxLvl_nxt;
  logic        devRstN_r, devRstN_nxt;
  logic [2:0]  sync_r, sync_nxt;

  assign busy    = (st_r != TW_IDLE);
  assign wrPhase = apValid_r && apWrite_r;
  assign startPulse = wrPhase && apAddr_r == `TW_OFS_CTRL &&
                      hwdata[`TW_CTRL_START] && !busy;
  assign finishPulse = (st_r == TW_GAP) && (half_r == 8'h00);

  // zero wait states: read data is prepared from the address phase
  always_comb begin
    apValid_nxt  = hsel && hready && htrans[1];
    apWrite_nxt  = hwrite;
    apAddr_nxt   = haddr[7:0];
    hrdata_nxt   = hrdata_r;
    txWord_nxt   = txWord_r;
    readMode_nxt = readMode_r;
    devRst_nxt   = devRst_r;
    done_nxt     = done_r;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `TW_OFS_CTRL:   hrdata_nxt = {30'h0, readMode_r, 1'b0};
        `TW_OFS_TXWORD: hrdata_nxt = {16'h0, txWord_r};
        `TW_OFS_STATUS: hrdata_nxt = {30'h0, done_r, busy};
        `TW_OFS_RXCODE: hrdata_nxt = {21'h0, rxCode_r};
        `TW_OFS_DEVRST: hrdata_nxt = {31'h0, devRst_r};
        default:        hrdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wrPhase) begin
      unique case (apAddr_r)
        `TW_OFS_CTRL: begin
          if (!busy) begin
            readMode_nxt = hwdata[`TW_CTRL_READ];
          end
        end
        `TW_OFS_TXWORD: begin
          if (!busy) begin
            txWord_nxt = hwdata[15:0];
          end
        end
        `TW_OFS_STATUS: begin
          if (hwdata[`TW_STAT_DONE]) begin
            done_nxt = 1'b0;
          end
        end
        `TW_OFS_DEVRST: devRst_nxt = hwdata[`TW_DEVRST_HOLD];
        default: ;
      endcase
    end
    // a finish in the clearing cycle keeps the flag set
    if (finishPulse) begin
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      apValid_r  <= 1'b0;
      apWrite_r  <= 1'b0;
      apAddr_r   <= 8'h00;
      hrdata_r   <= 32'h0000_0000;
      txWord_r   <= 16'h0000;
      readMode_r <= 1'b0;
      devRst_r   <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      apValid_r  <= apValid_nxt;
      apWrite_r  <= apWrite_nxt;
      apAddr_r   <= apAddr_nxt;
      hrdata_r   <= hrdata_nxt;
      txWord_r   <= txWord_nxt;
      readMode_r <= readMode_nxt;
      devRst_r   <= devRst_nxt;
      done_r     <= done_nxt;
    end
  end

  // link sequencer; every phase lasts HALF_CYC system clocks
  always_comb begin
    st_nxt     = st_r;
    half_nxt   = (half_r == 8'h00) ? 8'h00 : half_r - 8'h01;
    bitIdx_nxt = bitIdx_r;
    txSh_nxt   = txSh_r;
    rxSh_nxt   = rxSh_r;
    rxCode_nxt = rxCode_r;
    sclk_nxt   = sclk_r;
    selN_nxt   = selN_r;
    txBit_nxt  = txBit_r;
    rw_nxt     = rw_r;
    sync_nxt   = {sync_r[1:0], link.serialOut};
    rxLvl_nxt  = (sync_r[2] == sync_r[1]) ? sync_r[1] : rxLvl_r;
    // host reset also resets the device, so its bank never starts unknown
    devRstN_nxt = ~devRst_r; // see RQ11
    unique case (st_r)
      TW_IDLE: begin
        if (startPulse) begin
          selN_nxt   = 1'b0; // see RQ1, RQ6
          // the start write carries the direction; readMode_r lags a cycle
          rw_nxt     = hwdata[`TW_CTRL_READ]; // see RQ10
          txSh_nxt   = txWord_r;
          txBit_nxt  = txWord_r[15]; // see RQ3
          bitIdx_nxt = 4'hf;
          half_nxt   = HALF_LOAD;
          st_nxt     = TW_LOW;
        end
      end
      TW_LOW: begin
        if (half_r == 8'h00) begin
          sclk_nxt = 1'b1;
          half_nxt = HALF_LOAD;
          st_nxt   = TW_HIGH;
        end
      end
      TW_HIGH: begin
        if (half_r == 8'h00) begin
          // sampled just before the fall: the synchroniser needs
          // five clocks after the previous fall, more than one short phase
          rxSh_nxt = {rxSh_r[14:0], rxLvl_r}; // see RQ14
          sclk_nxt = 1'b0;
          half_nxt = HALF_LOAD;
          if (bitIdx_r == 4'h0) begin
            st_nxt = TW_HOLD; // see RQ7
          end else begin
            bitIdx_nxt = bitIdx_r - 4'h1;
            txSh_nxt   = {txSh_r[14:0], 1'b0};
            txBit_nxt  = txSh_r[14]; // see RQ3
            st_nxt     = TW_LOW;
          end
        end
      end
      TW_HOLD: begin
        if (half_r == 8'h00) begin
          selN_nxt   = 1'b1; // see RQ4
          rxCode_nxt = rxSh_r[10:0];
          half_nxt   = HALF_LOAD;
          st_nxt     = TW_GAP;
        end
      end
      TW_GAP: begin
        if (half_r == 8'h00) begin
          st_nxt = TW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r     <= TW_IDLE;
      half_r   <= 8'h00;
      bitIdx_r <= 4'h0;
      txSh_r   <= 16'h0000;
      rxSh_r   <= 16'h0000;
      rxCode_r <= 11'h000;
      sclk_r   <= 1'b0;
      selN_r   <= 1'b1;
      txBit_r  <= 1'b0;
      rw_r     <= 1'b0;
      rxLvl_r  <= 1'b0;
      sync_r   <= 3'h0;
      devRstN_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      half_r   <= half_nxt;
      bitIdx_r <= bitIdx_nxt;
      txSh_r   <= txSh_nxt;
      rxSh_r   <= rxSh_nxt;
      rxCode_r <= rxCode_nxt;
      sclk_r   <= sclk_nxt;
      selN_r   <= selN_nxt;
      txBit_r  <= txBit_nxt;
      rw_r     <= rw_nxt;
      rxLvl_r  <= rxLvl_nxt;
      sync_r   <= sync_nxt;
      devRstN_r <= devRstN_nxt;
    end
  end

  assign hrdata            = hrdata_r;
  assign hreadyout         = rst_n | ~rst_n;
  assign hresp             = 1'b0;
  assign link.sclk         = sclk_r;
  assign link.selectN      = selN_r;
  assign link.serialIn     = txBit_r;
  assign link.readNotWrite = rw_r;
  assign link.resetN       = devRstN_r;

endmodule

// ===== hw/tw_regs.svh
// constants for the three-wire channel programming port and its host
// assumes inclusion by bare name from files under hw/
`ifndef TW_REGS_SVH
`define TW_REGS_SVH

// serial word layout
`define TW_WORD_BITS      16
`define TW_ADDR_MSB       15
`define TW_ADDR_LSB       11
`define TW_ADDR_BITS      5
`define TW_CODE_MSB       10
`define TW_CODE_BITS      11
`define TW_CNT_BITS       5
`define TW_RD_START_CNT   5'h05
`define TW_FULL_CNT       5'h10

// channel bank: 18 gamma, common voltage and trim word
`define TW_NUM_CHAN       20
`define TW_CODE_RST       11'h000

// link timing
`define TW_SCLK_MIN_PERIOD_NS 200
`define TW_SYS_PERIOD_NS      8
`define TW_SCLK_MIN_CYC  ((`TW_SCLK_MIN_PERIOD_NS + `TW_SYS_PERIOD_NS - 1) / `TW_SYS_PERIOD_NS)
`define TW_HALF_CYC      ((`TW_SCLK_MIN_CYC + 1) / 2)

// host register offsets
`define TW_OFS_CTRL       8'h00
`define TW_OFS_TXWORD     8'h04
`define TW_OFS_STATUS     8'h08
`define TW_OFS_RXCODE     8'h0c
`define TW_OFS_DEVRST     8'h10

// host register fields
`define TW_CTRL_START     0
`define TW_CTRL_READ      1
`define TW_STAT_BUSY      0
`define TW_STAT_DONE      1
`define TW_DEVRST_HOLD    0

`endif

// ===== hw/tw_pkg.sv
// types shared by the three-wire port and its host controller
// assumes tw_regs.svh for the numeric constants
package tw_pkg;

  typedef enum logic [2:0] {
    TW_IDLE = 3'h0,
    TW_LOW  = 3'h1,
    TW_HIGH = 3'h3,
    TW_HOLD = 3'h2,
    TW_GAP  = 3'h6
  } tw_hst_e;

endpackage

// ===== hw/tw_link_if.sv
// three-wire link between host controller and programming port
// assumes the bench instantiates it and connects both ends
`timescale 1ns/10ps
interface tw_link_if;
  logic sclk;
  logic selectN;
  logic serialIn;
  logic serialOut;
  logic readNotWrite;
  logic resetN;

  modport dev (
    input  sclk,
    input  selectN,
    input  serialIn,
    input  readNotWrite,
    input  resetN,
    output serialOut
  );

  modport host (
    output sclk,
    output selectN,
    output serialIn,
    output readNotWrite,
    output resetN,
    input  serialOut
  );
endinterface

// ===== hw/tw_dev_port.sv
// device end: serial programming port and its channel code bank
// assumes the host keeps select and data stable around sclk edges
//
// Overview of operation
// (RQ1) active-low select frames every transfer word
// (RQ2) sample serial input on rising sclk edges
// (RQ3) host sends bit 15 first, bit 0 last
// (RQ4) select rising commits code to addressed channel
// (RQ5) sclk ignored while select is high
// (RQ6) host holds sclk low before select falls
// (RQ7) host frames carry at least sixteen bits
// (RQ8) bits 15 to 11 address the channel
// (RQ9) bits 10 to 0 are the code
// (RQ10) read/write select: zero writes, one reads
// (RQ11) reset pin low clears all registers
// (RQ12) serial output changes after falling sclk
// (RQ13) extra bits: last sixteen received are kept
// (RQ14) read mode shifts addressed code out, MSB first
`timescale 1ns/10ps
`include "tw_regs.svh"
module tw_dev_port
  import tw_pkg::*;
#(
  parameter int NUM_CHAN = `TW_NUM_CHAN
) (
  tw_link_if.dev                               link,
  output logic [NUM_CHAN-1:0][`TW_CODE_BITS-1:0] chanCode
);

  if (NUM_CHAN < 1 || NUM_CHAN > 32) begin : g_chk
    $error("NUM_CHAN must lie between 1 and 32");
  end

  logic [`TW_WORD_BITS-1:0] shift_r;
  logic [`TW_WORD_BITS-1:0] shift_nxt;
  logic [`TW_CNT_BITS-1:0]  cnt_r;
  logic [`TW_CNT_BITS-1:0]  cnt_nxt;
  logic [`TW_CODE_BITS-1:0] rdSh_r;
  logic [`TW_CODE_BITS-1:0] rdSh_nxt;
  logic [`TW_CODE_BITS-1:0] code_r [NUM_CHAN];
  logic [`TW_CODE_BITS-1:0] code_nxt [NUM_CHAN];
  logic [`TW_ADDR_BITS-1:0] wrAddr;
  logic [`TW_ADDR_BITS-1:0] rdAddr;
  logic [`TW_CODE_BITS-1:0] rdCode;
  logic                     wordFull;

  // msb arrives first, so shifting left leaves the last 16 bits
  always_comb begin
    shift_nxt = {shift_r[`TW_WORD_BITS-2:0], link.serialIn}; // see RQ2, RQ13
    cnt_nxt   = (cnt_r == `TW_FULL_CNT) ? cnt_r : cnt_r + 5'h01;
  end

  always_ff @(posedge link.sclk or negedge link.resetN) begin
    if (!link.resetN) begin
      shift_r <= 16'h0000; // see RQ11
    end else if (!link.selectN) begin
      shift_r <= shift_nxt; // see RQ1, RQ5
    end
  end

  // select high holds the counter clear, so stray sclk edges do nothing
  always_ff @(posedge link.sclk or posedge link.selectN
              or negedge link.resetN) begin
    if (!link.resetN) begin
      cnt_r <= 5'h00; // see RQ11
    end else if (link.selectN) begin
      cnt_r <= 5'h00; // see RQ5
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign wrAddr   = shift_r[`TW_ADDR_MSB:`TW_ADDR_LSB]; // see RQ8
  assign rdAddr   = shift_r[`TW_ADDR_BITS-1:0];
  assign wordFull = (cnt_r == `TW_FULL_CNT);

  always_comb begin
    rdCode = `TW_CODE_RST;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (rdAddr == i[`TW_ADDR_BITS-1:0]) begin
        rdCode = code_r[i];
      end
    end
  end

  // commit is clocked by the frame's own rising select; the counter
  // clear on that same edge relies on its reset path being slower
  // than the commit capture, a hold hazard to watch in layout
  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    always_comb begin
      code_nxt[i] = code_r[i];
      if (wordFull && !link.readNotWrite &&
          wrAddr == i[`TW_ADDR_BITS-1:0]) begin // see RQ4, RQ8, RQ10
        code_nxt[i] = shift_r[`TW_CODE_MSB:0]; // see RQ9
      end
    end

    always_ff @(posedge link.selectN or negedge link.resetN) begin
      if (!link.resetN) begin
        code_r[i] <= `TW_CODE_RST; // see RQ11
      end else begin
        code_r[i] <= code_nxt[i];
      end
    end

    assign chanCode[i] = code_r[i];
  end

  // after five address bits the code is loaded, then one bit per fall
  always_comb begin
    rdSh_nxt = {rdSh_r[`TW_CODE_BITS-2:0], 1'b0};
    if (link.readNotWrite && cnt_r == `TW_RD_START_CNT) begin
      rdSh_nxt = rdCode; // see RQ10, RQ14
    end
  end

  always_ff @(negedge link.sclk or posedge link.selectN
              or negedge link.resetN) begin
    if (!link.resetN) begin
      rdSh_r <= `TW_CODE_RST;
    end else if (link.selectN) begin
      rdSh_r <= `TW_CODE_RST;
    end else begin
      rdSh_r <= rdSh_nxt; // see RQ12
    end
  end

  assign link.serialOut = rdSh_r[`TW_CODE_MSB]; // see RQ14

endmodule

// ===== sim/tw_link_props.sv
// assertions on the three-wire link, sampled by the host clock
// assumes the bench instantiates it beside the link, host HALF_CYC of 4
`timescale 1ns/10ps
module tw_link_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic selectN,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic readNotWrite,
  input wire logic resetN
);
  logic [4:0] riseCnt_r;
  logic [4:0] riseCnt_nxt;
  logic       sclkQ_r;

  // counts sclk rises inside one frame
  always_comb begin
    riseCnt_nxt = riseCnt_r;
    if (selectN)
      riseCnt_nxt = 5'h00;
    else if (sclk && !sclkQ_r)
      riseCnt_nxt = riseCnt_r + 5'h01;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      riseCnt_r <= 5'h00;
      sclkQ_r   <= 1'b0;
    end else begin
      riseCnt_r <= riseCnt_nxt;
      sclkQ_r   <= sclk;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_idle_sclk_low: assert property (selectN |-> !sclk)
    else $error("sclk high outside a frame");
  chk_start_sclk_low: assert property (
    $fell(selectN) |-> !sclk && !$past(sclk))
    else $error("frame opened with sclk high");
  chk_high_width: assert property (
    $rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("sclk high phase width wrong");
  chk_low_width: assert property (
    $fell(sclk) && !selectN |-> !sclk[*4] ##1 (sclk || selectN))
    else $error("sclk low phase width wrong");
  chk_frame_bits: assert property (
    $rose(selectN) |-> riseCnt_r == 5'h10)
    else $error("frame closed without sixteen bits");
  chk_rw_stable: assert property (
    !selectN && !$past(selectN) |-> $stable(readNotWrite))
    else $error("direction changed inside a frame");
  chk_din_stable: assert property (
    $rose(sclk) |-> $stable(serialIn) && !selectN)
    else $error("serial input moved at sampling edge");
  chk_dout_edge: assert property ($changed(serialOut) |-> !sclk)
    else $error("serial output moved while sclk high");
  chk_dout_quiet: assert property (
    selectN || !readNotWrite |-> !serialOut)
    else $error("serial output active outside a read frame");
  chk_close_hold: assert property (
    $rose(selectN) |-> $past(sclk, 5) && !$past(sclk, 4))
    else $error("select rose at wrong distance from last bit");
endmodule

// ===== sim/tb_three_wire_channel_programming_port.sv
// testbench: AHB-Lite host controller driving the channel port
// assumes both ends meet in tw_link_if and the checker sits beside it
`timescale 1ns/10ps
module tb_three_wire_channel_programming_port;
  logic                 sys_clk;
  logic                 rst_n;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic [19:0][10:0]    chanCode;
  logic [31:0]          rd;
  int                   model[20];
  int                   numErrors;
  int                   nCompared;

  tw_link_if link();

  tw_host_ctrl #(.HALF_CYC(4)) u_tw_host_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(), .link(link));

  tw_dev_port #(.NUM_CHAN(20)) u_tw_dev_port (
    .link(link), .chanCode(chanCode));

  tw_link_props u_tw_link_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .sclk(link.sclk),
    .selectN(link.selectN), .serialIn(link.serialIn),
    .serialOut(link.serialOut), .readNotWrite(link.readNotWrite),
    .resetN(link.resetN));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one phase of a transfer; answer taken at the edge that ends it
  task automatic phase();
    do begin
      @(posedge sys_clk);
    end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    phase();
    htrans <= 2'h0;
    hwdata <= wd;
    phase();
  endtask

  task automatic check_chans();
    for (int i = 0; i < 20; i++)
      check("chanCode", model[i], {21'h0, chanCode[i]});
  endtask

  // bump rewrites word and start while busy; both must be refused
  task automatic frame(input logic [4:0] a, input logic [10:0] c,
                       input logic rdMode, input logic bump);
    int n;
    xfer(1'b1, 8'h04, {16'h0, a, c});
    xfer(1'b1, 8'h00, {30'h0, rdMode, 1'b1});
    if (bump) begin
      xfer(1'b1, 8'h04, {16'h0, a, ~c});
      xfer(1'b1, 8'h00, 32'h1);
    end
    n = 0;
    do begin
      xfer(1'b0, 8'h08, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 400);
    check("done", 32'h1, {31'h0, rd[1]});
    if (rdMode) begin
      xfer(1'b0, 8'h0c, 32'h0);
      check("rxCode", model[a], rd);
    end else if (a < 5'd20)
      model[a] = c;
    xfer(1'b1, 8'h08, 32'h2);
    xfer(1'b0, 8'h08, 32'h0);
    check("status", 32'h0, rd);
    check_chans();
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    numErrors++;
    $display("watchdog expired");
    test_done();
  end

  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rst_n = 1'b0;
    numErrors = 0;
    nCompared = 0;
    foreach (model[i]) model[i] = 0;
    void'($urandom(32'h1cfb63b8));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check_chans();
    xfer(1'b0, 8'h08, 32'h0);
    check("status", 32'h0, rd);
    xfer(1'b1, 8'h14, 32'hffffffff);
    xfer(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h0, rd);
    $display("test reset done");
    for (int a = 0; a < 32; a++)
      frame(5'(a), 11'($urandom), 1'b0, 1'b0);
    $display("test writes done");
    foreach (model[i])
      if (i % 6 == 1 || i == 19)
        frame(5'(i), 11'h7ff, 1'b1, 1'b0);
    $display("test reads done");
    frame(5'd3, 11'($urandom), 1'b0, 1'b1);
    $display("test busy done");
    xfer(1'b1, 8'h10, 32'h1);
    repeat (2) @(posedge sys_clk);
    foreach (model[i]) model[i] = 0;
    check_chans();
    xfer(1'b1, 8'h10, 32'h0);
    frame(5'd17, 11'($urandom), 1'b0, 1'b0);
    $display("test device reset done");
    test_done();
  end
endmodule
